// File: core/fault_escalation_sleep_entry.v
// Function
// - Vector fetch bus error is hard fault
// - Escalated fault sets escalation flag
// - Non-executable fetch faults even unprotected
// - Bus errors raise flagged bus fault
// - Usage errors each raise flagged usage fault
// - Foreign instruction set is bad state
// - Configurable fault priorities; hard fixed
// - Software enables per configurable handler
// - Same-kind fault in handler escalates
// - Fault under equal/higher priority escalates
// - Disabled handler's fault escalates
// - Bus handler entry push fault not escalated
// - Hard fault outranks all but reset/NMI
// - Capture address for protection and non-deferred bus faults
// - Hard fault in hard handler locks up
// - Deep-sleep bit selects sleep mode
// - Wait for interrupt sleeps immediately
// - Wait for event tests event latch
// - Sleep after handler returning to thread
// - Reserved return codes give usage fault
//
// The address map and the strobed register port were decided locally.
`timescale 1ns/10ps
`include "fault_escalation_regs.vh"
module fault_escalation_sleep_entry #(
  parameter ADDR_W = 8,
  parameter PRIO_W = 8
) (
  // Clock and reset
  input  wire              clk,
  input  wire              rst,
  // Register port
  input  wire [ADDR_W-1:0] reg_addr,
  input  wire [31:0]       reg_wdata,
  input  wire              reg_wr,
  input  wire              reg_rd,
  output reg  [31:0]       reg_rdata,
  // Hard fault sources
  input  wire              vector_fetch_error,
  // Protection unit reports
  input  wire              prot_instr_mismatch,
  input  wire              non_executable_attr,
  input  wire              prot_data_mismatch,
  input  wire              prot_stacking_mismatch,
  input  wire              prot_unstacking_mismatch,
  input  wire [31:0]       prot_access_addr,
  // Bus reports
  input  wire              bus_stacking_error,
  input  wire              bus_unstacking_error,
  input  wire              prefetch_bus_error,
  input  wire              exact_data_bus_error,
  input  wire              deferred_data_bus_error,
  input  wire [31:0]       bus_access_addr,
  // Pipeline reports
  input  wire              coproc_access,
  input  wire              undefined_opcode,
  input  wire              bad_exec_state,
  input  wire              foreign_isa_switch,
  input  wire              unaligned_access,
  input  wire              zero_divisor,
  input  wire              exception_return,
  input  wire [3:0]        exception_return_code,
  // Execution context
  input  wire              handler_active,
  input  wire [PRIO_W-1:0] current_priority,
  input  wire [2:0]        active_class,
  input  wire              hard_handler_active,
  input  wire              nmi_handler_active,
  input  wire              bus_handler_entry,
  // Sleep requests
  input  wire              wait_interrupt_instr,
  input  wire              wait_event_instr,
  input  wire              event_in,
  input  wire              wake,
  // Exception requests
  output reg               take_hard_fault,
  output reg               take_prot_fault,
  output reg               take_bus_fault,
  output reg               take_usage_fault,
  // Core status
  output reg               lockup,
  output reg               sleeping,
  output reg               deep_sleep,
  output reg               halt
);

  localparam CLASSES = 3;
  localparam ST_RUN  = 2'b01;
  localparam ST_LOCK = 2'b10;

  reg  [1:0]              state;
  reg  [1:0]              next_state;
  reg  [1:0]              hard_fault_status;
  reg  [7:0]              protection_fault_status;
  reg  [7:0]              bus_fault_status;
  reg  [5:0]              usage_fault_status;
  reg  [31:0]             protection_fault_address;
  reg  [31:0]             bus_fault_address;
  reg  [1:0]              system_control_reg;
  reg  [CLASSES*PRIO_W-1:0] handler_priority;
  reg  [CLASSES-1:0]      handler_enable;

  wire [3:0]              prot_ev;
  wire [4:0]              bus_ev;
  wire [5:0]              usage_ev;
  wire                    bad_return;
  wire [CLASSES-1:0]      fault_req;
  wire [CLASSES-1:0]      exempt;
  wire [CLASSES-1:0]      escalate;
  wire [CLASSES-1:0]      direct;
  wire                    escalated;
  wire                    hard_now;
  wire                    fixed_active;
  wire                    return_to_thread;
  wire                    sleep_state;
  wire                    deep_state;
  wire                    event_latch;
  wire                    wr_hfs;
  wire                    wr_pfs;
  wire                    wr_bfs;
  wire                    wr_ufs;
  wire                    wr_pfa;
  wire                    wr_bfa;

  // Return code decode: only three defined encodings
  assign bad_return = exception_return &&
                      exception_return_code != `RET_HANDLER_MAIN &&
                      exception_return_code != `RET_THREAD_MAIN &&
                      exception_return_code != `RET_THREAD_PROCESS;
  assign return_to_thread = exception_return && !bad_return &&
                            exception_return_code != `RET_HANDLER_MAIN;

  // Protection events, non-executable counts regardless of unit state
  assign prot_ev[`PFS_INSTR_ACCESS] = prot_instr_mismatch ||
                                      non_executable_attr;
  assign prot_ev[`PFS_DATA_ACCESS]  = prot_data_mismatch;
  assign prot_ev[`PFS_UNSTACKING]   = prot_unstacking_mismatch;
  assign prot_ev[`PFS_STACKING]     = prot_stacking_mismatch;

  // Bus events
  assign bus_ev[`BFS_PREFETCH]      = prefetch_bus_error;
  assign bus_ev[`BFS_EXACT_DATA]    = exact_data_bus_error;
  assign bus_ev[`BFS_DEFERRED_DATA] = deferred_data_bus_error;
  assign bus_ev[`BFS_UNSTACKING]    = bus_unstacking_error;
  assign bus_ev[`BFS_STACKING]      = bus_stacking_error;

  // Usage events
  assign usage_ev[`UFS_UNDEFINED]    = undefined_opcode;
  assign usage_ev[`UFS_BAD_STATE]    = bad_exec_state ||
                                       foreign_isa_switch;
  assign usage_ev[`UFS_BAD_RETURN]   = bad_return;
  assign usage_ev[`UFS_COPROC]       = coproc_access;
  assign usage_ev[`UFS_UNALIGNED]    = unaligned_access;
  assign usage_ev[`UFS_ZERO_DIVISOR] = zero_divisor;

  assign fault_req    = {|usage_ev, |bus_ev, |prot_ev};
  // Push failure on bus handler entry proceeds to the handler
  assign exempt       = {1'b0, bus_handler_entry && bus_stacking_error,
                         1'b0};
  assign fixed_active = hard_handler_active || nmi_handler_active;

  fault_escalator #(
    .CLASSES (CLASSES),
    .PRIO_W  (PRIO_W)
  ) u_escalator (
    .fault_req        (fault_req),
    .escalate_exempt  (exempt),
    .class_priority   (handler_priority),
    .class_enable     (handler_enable),
    .handler_active   (handler_active),
    .fixed_active     (fixed_active),
    .current_priority (current_priority),
    .active_class     (active_class),
    .escalate         (escalate)
  );

  assign escalated = |escalate;
  assign hard_now  = vector_fetch_error || escalated;
  assign direct    = fault_req & ~escalate;

  // Run and lockup states
  always @* begin
    next_state = state;
    case (state)
      ST_RUN: begin
        // Hard fault inside hard or NMI handler cannot be taken
        if (hard_now && fixed_active)
          next_state = ST_LOCK;
      end
      ST_LOCK: begin
        next_state = ST_LOCK;
      end
      default: begin
        next_state = ST_RUN;
      end
    endcase
  end

  sleep_entry u_sleep (
    .clk                  (clk),
    .rst                  (rst),
    .wait_interrupt_instr (wait_interrupt_instr),
    .wait_event_instr     (wait_event_instr),
    .return_to_thread     (return_to_thread),
    .event_in             (event_in),
    .wake                 (wake),
    .inhibit              (state == ST_LOCK),
    .sleep_after_handler  (system_control_reg[0]),
    .deep_sleep_select    (system_control_reg[1]),
    .sleeping             (sleep_state),
    .deep                 (deep_state),
    .event_latch          (event_latch)
  );

  // Register write decode
  assign wr_hfs = reg_wr && reg_addr == `OFS_HARD_FAULT_STATUS;
  assign wr_pfs = reg_wr && reg_addr == `OFS_PROT_FAULT_STATUS;
  assign wr_bfs = reg_wr && reg_addr == `OFS_BUS_FAULT_STATUS;
  assign wr_ufs = reg_wr && reg_addr == `OFS_USAGE_FAULT_STATUS;
  assign wr_pfa = reg_wr && reg_addr == `OFS_PROT_FAULT_ADDRESS;
  assign wr_bfa = reg_wr && reg_addr == `OFS_BUS_FAULT_ADDRESS;

  // Control registers
  always @(posedge clk) begin
    if (rst) begin
      system_control_reg <= `RST_SYSTEM_CONTROL;
      handler_priority   <= `RST_HANDLER_PRIORITY;
      handler_enable     <= `RST_HANDLER_ENABLE;
    end else if (reg_wr) begin
      if (reg_addr == `OFS_SYSTEM_CONTROL_REG)
        system_control_reg <=
          {reg_wdata[`SYS_DEEP_SLEEP_SELECT],
           reg_wdata[`SYS_SLEEP_AFTER_HANDLER]};
      if (reg_addr == `OFS_HANDLER_PRIORITY)
        handler_priority <= reg_wdata[CLASSES*PRIO_W-1:0];
      if (reg_addr == `OFS_HANDLER_ENABLE)
        handler_enable <= reg_wdata[CLASSES-1:0];
    end
  end

  // Sticky cause flags: write one clears, new event wins
  always @(posedge clk) begin
    if (rst) begin
      hard_fault_status       <= 2'h0;
      protection_fault_status <= 8'h00;
      bus_fault_status        <= 8'h00;
      usage_fault_status      <= 6'h00;
    end else begin
      hard_fault_status <=
        (hard_fault_status & ~({2{wr_hfs}} & reg_wdata[1:0])) |
        {escalated, vector_fetch_error};
      protection_fault_status[3:0] <=
        (protection_fault_status[3:0] & ~({4{wr_pfs}} & reg_wdata[3:0])) |
        prot_ev;
      bus_fault_status[4:0] <=
        (bus_fault_status[4:0] & ~({5{wr_bfs}} & reg_wdata[4:0])) |
        bus_ev;
      usage_fault_status <=
        (usage_fault_status & ~({6{wr_ufs}} & reg_wdata[5:0])) |
        usage_ev;
      if (|prot_ev)
        protection_fault_status[`PFS_ADDR_VALID] <= 1'b1;
      else if (wr_pfa || (wr_pfs && reg_wdata[`PFS_ADDR_VALID]))
        protection_fault_status[`PFS_ADDR_VALID] <= 1'b0;
      if (|bus_ev[1:0] || |bus_ev[4:3])
        bus_fault_status[`BFS_ADDR_VALID] <= 1'b1;
      else if (wr_bfa || (wr_bfs && reg_wdata[`BFS_ADDR_VALID]))
        bus_fault_status[`BFS_ADDR_VALID] <= 1'b0;
      protection_fault_status[6:4] <= 3'h0;
      bus_fault_status[6:5]        <= 2'h0;
    end
  end

  // Fault address capture, first fault held until cleared
  always @(posedge clk) begin
    if (rst) begin
      protection_fault_address <= 32'h00000000;
      bus_fault_address        <= 32'h00000000;
    end else begin
      if (|prot_ev &&
          (!protection_fault_status[`PFS_ADDR_VALID] || wr_pfa))
        protection_fault_address <= prot_access_addr;
      else if (wr_pfa)
        protection_fault_address <= 32'h00000000;
      if ((|bus_ev[1:0] || |bus_ev[4:3]) &&
          (!bus_fault_status[`BFS_ADDR_VALID] || wr_bfa))
        bus_fault_address <= bus_access_addr;
      else if (wr_bfa)
        bus_fault_address <= 32'h00000000;
    end
  end

  // Exception requests and status outputs
  always @(posedge clk) begin
    if (rst) begin
      state            <= ST_RUN;
      take_hard_fault  <= 1'b0;
      take_prot_fault  <= 1'b0;
      take_bus_fault   <= 1'b0;
      take_usage_fault <= 1'b0;
      lockup           <= 1'b0;
      sleeping         <= 1'b0;
      deep_sleep       <= 1'b0;
      halt             <= 1'b0;
    end else begin
      state <= next_state;
      // Hard fault outranks configurable classes
      take_hard_fault  <= state == ST_RUN && hard_now &&
                          !fixed_active;
      take_prot_fault  <= state == ST_RUN && !hard_now && direct[0];
      take_bus_fault   <= state == ST_RUN && !hard_now && !direct[0] &&
                          direct[1];
      take_usage_fault <= state == ST_RUN && !hard_now && !direct[0] &&
                          !direct[1] && direct[2];
      lockup           <= next_state == ST_LOCK;
      sleeping         <= sleep_state;
      deep_sleep       <= deep_state;
      halt             <= next_state == ST_LOCK || sleep_state;
    end
  end

  // Read port, data one cycle after the strobe
  always @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      case (reg_addr)
        `OFS_HARD_FAULT_STATUS:
          reg_rdata <= {30'h00000000, hard_fault_status};
        `OFS_PROT_FAULT_STATUS:
          reg_rdata <= {24'h000000, protection_fault_status};
        `OFS_BUS_FAULT_STATUS:
          reg_rdata <= {24'h000000, bus_fault_status};
        `OFS_USAGE_FAULT_STATUS:
          reg_rdata <= {26'h0000000, usage_fault_status};
        `OFS_PROT_FAULT_ADDRESS:
          reg_rdata <= protection_fault_address;
        `OFS_BUS_FAULT_ADDRESS:
          reg_rdata <= bus_fault_address;
        `OFS_SYSTEM_CONTROL_REG:
          reg_rdata <= {29'h00000000, system_control_reg, 1'b0};
        `OFS_HANDLER_PRIORITY:
          reg_rdata <= {{(32-CLASSES*PRIO_W){1'b0}}, handler_priority};
        `OFS_HANDLER_ENABLE:
          reg_rdata <= {{(32-CLASSES){1'b0}}, handler_enable};
        `OFS_CORE_STATE:
          reg_rdata <= {28'h0000000, event_latch, deep_state,
                        sleep_state, state == ST_LOCK};
        default:
          reg_rdata <= 32'h00000000;
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

endmodule

// File: core/fault_escalation_regs.vh
`ifndef FAULT_ESCALATION_REGS_VH
`define FAULT_ESCALATION_REGS_VH

// Register offsets (byte addresses, one word each)
`define OFS_HARD_FAULT_STATUS   8'h00
`define OFS_PROT_FAULT_STATUS   8'h04
`define OFS_BUS_FAULT_STATUS    8'h08
`define OFS_USAGE_FAULT_STATUS  8'h0C
`define OFS_PROT_FAULT_ADDRESS  8'h10
`define OFS_BUS_FAULT_ADDRESS   8'h14
`define OFS_SYSTEM_CONTROL_REG  8'h18
`define OFS_HANDLER_PRIORITY    8'h1C
`define OFS_HANDLER_ENABLE      8'h20
`define OFS_CORE_STATE          8'h24

// Hard fault status fields
`define HFS_VECTOR_FETCH        0
`define HFS_ESCALATION          1

// Protection fault status fields
`define PFS_INSTR_ACCESS        0
`define PFS_DATA_ACCESS         1
`define PFS_UNSTACKING          2
`define PFS_STACKING            3
`define PFS_ADDR_VALID          7

// Bus fault status fields
`define BFS_PREFETCH            0
`define BFS_EXACT_DATA          1
`define BFS_DEFERRED_DATA       2
`define BFS_UNSTACKING          3
`define BFS_STACKING            4
`define BFS_ADDR_VALID          7

// Usage fault status fields
`define UFS_UNDEFINED           0
`define UFS_BAD_STATE           1
`define UFS_BAD_RETURN          2
`define UFS_COPROC              3
`define UFS_UNALIGNED           4
`define UFS_ZERO_DIVISOR        5

// System control fields
`define SYS_SLEEP_AFTER_HANDLER 1
`define SYS_DEEP_SLEEP_SELECT   2

// Core state fields
`define CST_LOCKUP              0
`define CST_SLEEPING            1
`define CST_DEEP                2
`define CST_EVENT_LATCH         3

// Reset values
`define RST_HANDLER_PRIORITY    24'h000000
`define RST_HANDLER_ENABLE      3'h0
`define RST_SYSTEM_CONTROL      2'h0

// Defined return codes in the low four bits
`define RET_HANDLER_MAIN        4'h1
`define RET_THREAD_MAIN         4'h9
`define RET_THREAD_PROCESS      4'hD

`endif

// File: core/fault_escalator.v
`timescale 1ns/10ps
module fault_escalator #(
  parameter CLASSES = 3,
  parameter PRIO_W  = 8
) (
  // Fault requests per configurable class
  input  wire [CLASSES-1:0]        fault_req,
  input  wire [CLASSES-1:0]        escalate_exempt,
  // Software controls
  input  wire [CLASSES*PRIO_W-1:0] class_priority,
  input  wire [CLASSES-1:0]        class_enable,
  // Execution context
  input  wire                      handler_active,
  input  wire                      fixed_active,
  input  wire [PRIO_W-1:0]         current_priority,
  input  wire [CLASSES-1:0]        active_class,
  // Decision
  output wire [CLASSES-1:0]        escalate
);

  genvar i;
  generate
    for (i = 0; i < CLASSES; i = i + 1) begin : g_class
      wire [PRIO_W-1:0] prio;
      wire              blocked;
      assign prio = class_priority[i*PRIO_W +: PRIO_W];
      // Handler cannot preempt equal or higher priority context
      assign blocked = (handler_active && current_priority <= prio) ||
                       fixed_active;
      // Disabled handler, own class active, or blocked
      assign escalate[i] = fault_req[i] && !escalate_exempt[i] &&
                           (!class_enable[i] || active_class[i] ||
                            blocked);
    end
  endgenerate

endmodule

// File: core/sleep_entry.v
`timescale 1ns/10ps
module sleep_entry (
  // Clock and reset
  input  wire clk,
  input  wire rst,
  // Requests
  input  wire wait_interrupt_instr,
  input  wire wait_event_instr,
  input  wire return_to_thread,
  input  wire event_in,
  input  wire wake,
  input  wire inhibit,
  // Controls
  input  wire sleep_after_handler,
  input  wire deep_sleep_select,
  // State
  output reg  sleeping,
  output reg  deep,
  output reg  event_latch
);

  wire evt_sleep;
  wire enter;

  // Event latch tested by wait for event
  assign evt_sleep = wait_event_instr && !event_latch;
  assign enter = !inhibit && (wait_interrupt_instr || evt_sleep ||
                 (return_to_thread && sleep_after_handler));

  always @(posedge clk) begin
    if (rst) begin
      sleeping    <= 1'b0;
      deep        <= 1'b0;
      event_latch <= 1'b0;
    end else begin
      // New event wins over the clear by wait for event
      if (event_in)
        event_latch <= 1'b1;
      else if (wait_event_instr && event_latch)
        event_latch <= 1'b0;
      if (enter) begin
        sleeping <= 1'b1;
        deep     <= deep_sleep_select;
      end else if (wake || inhibit) begin
        sleeping <= 1'b0;
        deep     <= 1'b0;
      end
    end
  end

endmodule

// File: bench/fault_checker_assertions.sv
`timescale 1ns/10ps
module fault_checker (
  // Clock and reset
  input logic clk,
  input logic rst,
  // Stimulus seen at the ports
  input logic vector_fetch_error,
  input logic hard_handler_active,
  input logic nmi_handler_active,
  input logic wait_interrupt_instr,
  input logic wake,
  // Exception requests
  input logic take_hard_fault,
  input logic take_prot_fault,
  input logic take_bus_fault,
  input logic take_usage_fault,
  // Core status
  input logic lockup,
  input logic sleeping,
  input logic halt
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  property p_lock_hold;
    lockup |=> lockup;
  endproperty
  a_lock_hold: assert property (p_lock_hold)
    else $error("lockup released without reset");

  property p_lock_entry;
    vector_fetch_error && hard_handler_active |=> lockup;
  endproperty
  a_lock_entry: assert property (p_lock_entry)
    else $error("hard fault in hard handler did not lock");

  property p_lock_quiet;
    lockup |-> !(take_hard_fault || take_prot_fault || take_bus_fault
                 || take_usage_fault);
  endproperty
  a_lock_quiet: assert property (p_lock_quiet)
    else $error("exception taken while locked");

  property p_one_take;
    $onehot0({take_hard_fault, take_prot_fault, take_bus_fault,
              take_usage_fault});
  endproperty
  a_one_take: assert property (p_one_take)
    else $error("more than one exception taken at once");

  property p_vec_hard;
    vector_fetch_error && !hard_handler_active && !nmi_handler_active
      && !lockup |=> take_hard_fault;
  endproperty
  a_vec_hard: assert property (p_vec_hard)
    else $error("vector fetch error not taken as hard fault");

  property p_slp;
    wait_interrupt_instr && !wake && !lockup ##1 !wake && !lockup
      |=> sleeping;
  endproperty
  a_slp: assert property (p_slp)
    else $error("wait for interrupt did not sleep");

  property p_halt;
    sleeping |-> halt;
  endproperty
  a_halt: assert property (p_halt)
    else $error("sleeping without halt");

  property p_sleep_hold;
    sleeping && !wake && !$past(wake) && !lockup |=> sleeping;
  endproperty
  a_sleep_hold: assert property (p_sleep_hold)
    else $error("sleep left without wake");

  c_lock: cover property (lockup);
  c_sleep: cover property (sleeping);
  c_bus: cover property (take_bus_fault);
endmodule

bind fault_escalation_sleep_entry fault_checker chk (.*);

// File: bench/fault_source.sv
`timescale 1ns/10ps
module fault_source (
  // Clock
  input  logic        clk,
  // Event lines and access address
  output logic [16:0] ev,
  output logic [31:0] addr
);
  initial begin
    ev = 17'h00000;
    addr = 32'h00000000;
  end
  // One-cycle event with its address; address no longer valid afterwards
  task fire(input int i, input logic [31:0] a);
    @(posedge clk);
    ev <= 17'h00001 << i;
    addr <= a;
    @(posedge clk);
    ev <= 17'h00000;
    addr <= ~a;
  endtask
endmodule

// File: bench/tb_top.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin \
  check_count++; \
  if ((g) !== (e)) begin \
    fails++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); \
  end \
end
module tb_top;
  logic        clk, rst, reg_wr, reg_rd, handler_active, hard_act, bus_entry;
  logic        nmi_act;
  logic [7:0]  reg_addr, cur_pri;
  logic [31:0] reg_wdata;
  logic [4:0]  ctl;
  logic [3:0]  ret_code;
  logic [2:0]  act_cls;
  wire  [31:0] reg_rdata, src_addr;
  wire  [16:0] ev;
  wire  [3:0]  take;
  wire         lockup, sleeping, deep_sleep, halt;
  int          fails, check_count, cyc;

  fault_source src (.clk(clk), .ev(ev), .addr(src_addr));
  fault_escalation_sleep_entry dut (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .vector_fetch_error(ev[0]), .prot_instr_mismatch(ev[1]),
    .non_executable_attr(ev[2]), .prot_data_mismatch(ev[3]),
    .prot_stacking_mismatch(ev[4]), .prot_unstacking_mismatch(ev[5]),
    .prot_access_addr(src_addr), .bus_stacking_error(ev[6]),
    .bus_unstacking_error(ev[7]), .prefetch_bus_error(ev[8]),
    .exact_data_bus_error(ev[9]), .deferred_data_bus_error(ev[10]),
    .bus_access_addr(src_addr), .coproc_access(ev[11]),
    .undefined_opcode(ev[12]), .bad_exec_state(ev[13]),
    .foreign_isa_switch(ev[14]), .unaligned_access(ev[15]),
    .zero_divisor(ev[16]), .exception_return(ctl[4]),
    .exception_return_code(ret_code), .handler_active(handler_active),
    .current_priority(cur_pri), .active_class(act_cls),
    .hard_handler_active(hard_act), .nmi_handler_active(nmi_act),
    .bus_handler_entry(bus_entry), .wait_interrupt_instr(ctl[0]),
    .wait_event_instr(ctl[1]), .event_in(ctl[2]), .wake(ctl[3]),
    .take_hard_fault(take[3]), .take_prot_fault(take[2]),
    .take_bus_fault(take[1]), .take_usage_fault(take[0]),
    .lockup(lockup), .sleeping(sleeping), .deep_sleep(deep_sleep),
    .halt(halt)
  );

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      conclude;
    end
  end

  task conclude;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e, input string n);
    logic [31:0] d;
    @(posedge clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'h0;
    #1 d = reg_rdata;
    `CHK(n, e, d)
  endtask

  // Fire one event and judge the exception request that follows
  task hit(input int i, input logic [31:0] a, input logic [3:0] e,
           input string n);
    src.fire(i, a);
    #1 `CHK(n, e, take)
  endtask

  task pul(input int i);
    @(posedge clk);
    ctl <= 5'h01 << i;
    @(posedge clk);
    ctl <= 5'h00;
  endtask

  task nap(input logic e, input string n);
    @(posedge clk);
    #1 `CHK(n, e, sleeping)
  endtask

  task t_regs;
    rd(8'h20, 32'h0, "enables at reset");
    rd(8'h18, 32'h0, "control at reset");
    hit(12, 32'h0, 4'h8, "disabled usage take");
    rd(8'h00, 32'h2, "escalation flag");
    rd(8'h0C, 32'h1, "usage cause kept");
    wr(8'h00, 32'hFF);
    rd(8'h00, 32'h0, "hard status cleared");
    wr(8'h0C, 32'hFF);
    wr(8'h1C, 32'h00302010);
    rd(8'h1C, 32'h00302010, "priorities");
    wr(8'h20, 32'h7);
    rd(8'h20, 32'h7, "enables");
    rd(8'h80, 32'h0, "unmapped read");
    $display("test regs done");
  endtask

  task t_usage;
    int ui[6] = '{11, 12, 13, 14, 15, 16};
    int ub[6] = '{3, 0, 1, 1, 4, 5};
    for (int k = 0; k < 6; k++) begin
      hit(ui[k], 32'h0, 4'h1, "usage take");
      rd(8'h0C, 32'h1 << ub[k], "usage status");
      wr(8'h0C, 32'hFF);
    end
    ret_code <= 4'h3;
    pul(4);
    #1 `CHK("bad return take", 4'h1, take)
    rd(8'h0C, 32'h4, "bad return flag");
    wr(8'h0C, 32'hFF);
    $display("test usage done");
  endtask

  task t_prot;
    int pb[5] = '{0, 0, 1, 3, 2};
    for (int k = 0; k < 5; k++) begin
      hit(k + 1, 32'h1000 + k, 4'h4, "prot take");
      rd(8'h04, (32'h1 << pb[k]) | 32'h80, "prot status");
      rd(8'h10, 32'h1000 + k, "prot address");
      wr(8'h04, 32'hFF);
      wr(8'h10, 32'h0);
    end
    hit(3, 32'hA0, 4'h4, "first prot take");
    hit(3, 32'hB0, 4'h4, "second prot take");
    rd(8'h10, 32'hA0, "first address held");
    rd(8'h04, 32'h82, "prot flags held");
    wr(8'h04, 32'hFF);
    wr(8'h10, 32'h0);
    $display("test prot done");
  endtask

  task t_bus;
    int bb[5] = '{4, 3, 0, 1, 2};
    for (int k = 0; k < 5; k++) begin
      hit(k + 6, 32'h2000 + k, 4'h2, "bus take");
      rd(8'h08, (32'h1 << bb[k]) | (k < 4 ? 32'h80 : 32'h0),
         "bus status");
      rd(8'h14, k < 4 ? 32'h2000 + k : 32'h0, "bus address");
      wr(8'h08, 32'hFF);
      wr(8'h14, 32'h0);
    end
    $display("test bus done");
  endtask

  // Run one fault under a handler context, then clear what it left
  task esc(input logic [7:0] p, input logic [2:0] c, input logic b,
           input int i, input logic [3:0] e, input string n);
    handler_active <= 1'h1;
    cur_pri <= p;
    act_cls <= c;
    bus_entry <= b;
    hit(i, 32'h40, e, n);
    handler_active <= 1'h0;
    act_cls <= 3'h0;
    bus_entry <= 1'h0;
    wr(8'h00, 32'hFF);
    wr(8'h08, 32'hFF);
    wr(8'h14, 32'h0);
  endtask

  task t_esc;
    esc(8'h20, 3'h0, 1'h0, 9, 4'h8, "equal priority");
    esc(8'h30, 3'h0, 1'h0, 9, 4'h2, "lower priority");
    esc(8'h30, 3'h2, 1'h0, 9, 4'h8, "same kind");
    esc(8'h30, 3'h2, 1'h1, 6, 4'h2, "entry push");
    esc(8'h00, 3'h1, 1'h0, 0, 4'h8, "hard preempts");
    $display("test escalation done");
  endtask

  task t_sleep;
    wr(8'h18, 32'h4);
    pul(0);
    @(posedge clk);
    #1 `CHK("deep sleep", 3'h7, {sleeping, deep_sleep, halt})
    pul(3);
    nap(1'h0, "woken");
    wr(8'h18, 32'h0);
    pul(2);
    pul(1);
    nap(1'h0, "event latch set");
    pul(1);
    nap(1'h1, "event latch clear");
    #0 `CHK("normal sleep", 1'h0, deep_sleep)
    pul(3);
    nap(1'h0, "woken");
    wr(8'h18, 32'h2);
    ret_code <= 4'h1;
    pul(4);
    nap(1'h0, "return to handler");
    ret_code <= 4'h9;
    pul(4);
    nap(1'h1, "return to thread");
    pul(3);
    nap(1'h0, "woken");
    ret_code <= 4'hD;
    pul(4);
    nap(1'h1, "return to thread process");
    pul(3);
    nap(1'h0, "woken");
    $display("test sleep done");
  endtask

  task t_lock;
    hit(0, 32'h0, 4'h8, "vector fetch take");
    rd(8'h00, 32'h1, "vector fetch flag");
    hard_act <= 1'h1;
    hit(0, 32'h0, 4'h0, "no take when locking");
    `CHK("lockup", 1'h1, lockup)
    hard_act <= 1'h0;
    hit(12, 32'h0, 4'h0, "no take in lockup");
    pul(0);
    nap(1'h0, "no sleep in lockup");
    `CHK("lockup held", 1'h1, lockup)
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    nmi_act <= 1'h1;
    hit(12, 32'h0, 4'h0, "no take in nmi");
    `CHK("nmi lockup", 1'h1, lockup)
    $display("test lockup done");
  endtask

  initial begin
    rst = 1'h1;
    {reg_wr, reg_rd, handler_active, hard_act, bus_entry, nmi_act} = 6'h00;
    {reg_addr, cur_pri, reg_wdata, ctl, ret_code, act_cls} = '0;
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    t_regs;
    t_usage;
    t_prot;
    t_bus;
    t_esc;
    t_sleep;
    t_lock;
    conclude;
  end
endmodule
